// ===== acp_analog_model.sv
// Behavioural analog comparator core facing the control block
`timescale 1ns/1ps
module acp_analog_model (
  input wire logic power_off,
  input wire logic [1:0] pos_src,
  input wire logic neg_conv,
  input wire logic [1:0] neg_pin,
  input wire logic [11:0] mv_a,
  input wire logic [11:0] mv_b,
  input wire logic [11:0] mv_c,
  input wire logic [11:0] mv_conv,
  output logic result
);
  logic [11:0] pos_mv; // Level on the positive side, millivolts
  logic [11:0] neg_mv; // Level on the negative side, millivolts
  ////////////////////////////////////////
  // Input muxes, then the compare; an unpowered core reads low
  always_comb begin
    case (pos_src)
      2'h0: pos_mv = mv_a;
      2'h1: pos_mv = mv_b;
      2'h2: pos_mv = mv_c;
      default: pos_mv = 12'h44C; // Internal reference
    endcase
    case (neg_pin)
      2'h0: neg_mv = mv_a;
      2'h1: neg_mv = mv_b;
      default: neg_mv = mv_c;
    endcase
    if (neg_conv) begin
      neg_mv = mv_conv; // Converter channel wins
    end
    result = !power_off && (pos_mv > neg_mv);
  end
endmodule // acp_analog_model

// ===== acp_comparator_ctrl.sv
// Top: comparator control registers, event flag and input disable
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module acp_comparator_ctrl import acp_pkg::*; #(
  parameter int CONV_PINS = 11 // Converter pins with input buffers
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CPU interrupt side
  input wire logic global_irq_en,
  input wire logic irq_vector_ack,
  output logic irq_req,
  // Analog comparator core
  input wire logic raw_result,
  input wire logic converter_enable,
  output logic cmp_power_off,
  output logic [1:0] cmp_pos_source,
  output logic cmp_neg_from_conv,
  output logic [1:0] cmp_neg_pin,
  output logic hysteresis_on,
  output logic hysteresis_level,
  // Pin input buffers
  input wire logic [CONV_PINS-1:0] conv_pin_raw,
  input wire logic ref_pin_raw,
  output logic [CONV_PINS-1:0] conv_pin_buffer_off,
  output logic ref_pin_buffer_off,
  output logic [CONV_PINS-1:0] conv_pin_read,
  output logic ref_pin_read
);

  ////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    logic [7:0] ctrl_a; // Control A, result bit unused here
    logic [7:0] ctrl_b; // Control B
    logic [7:0] dis_low; // Low disable register
    logic [7:0] dis_high; // High disable register
    logic [7:0] rdata; // Read data, one cycle later
    logic irq; // Interrupt request
    logic power_off; // Registered power-off output
    logic [1:0] pos_src; // Registered positive source
    logic neg_conv; // Registered negative from mux
    logic [1:0] neg_pin; // Registered negative pin
    logic hyst_on; // Registered hysteresis enable
    logic hyst_lvl; // Registered hysteresis level
    logic [CONV_PINS-1:0] conv_off; // Registered buffer disables
    logic ref_off; // Registered reference disable
    logic [CONV_PINS-1:0] conv_rd; // Gated pin read values
    logic ref_rd; // Gated reference read value
  } acp_state_type;

  acp_state_type st_ff;
  acp_state_type nxt_st;

  localparam acp_state_type ACP_RST_STATE = '{
    ctrl_a: ACP_RST_CTRL_A,
    ctrl_b: ACP_RST_CTRL_B,
    dis_low: ACP_RST_DISABLE_LOW,
    dis_high: ACP_RST_DISABLE_HIGH,
    default: '0
  };

  ////////////////////////////////////////////////////////////////////////
  // Synchronizer and event detect
  acp_sync_if sync ();

  acp_sync_detect u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .raw_result(raw_result), // polarity kept from the core
    .sync(sync)
  );

  // Mode straight from the stored field
  assign sync.mode = {st_ff.ctrl_a[ACP_A_MODE_HI],
                      st_ff.ctrl_a[ACP_A_MODE_LO]};

  ////////////////////////////////////////////////////////////////////////
  // Input routing decode
  logic [1:0] route_pos; // Decoded positive source
  logic route_neg_conv; // Decoded mux-to-negative
  logic [1:0] route_neg_pin; // Decoded negative pin

  acp_input_route u_route (
    .sel(st_ff.ctrl_b[ACP_B_SEL_HI:0]),
    .bandgap(st_ff.ctrl_a[ACP_A_BANDGAP]),
    .mux_neg(st_ff.ctrl_a[ACP_A_MUX_NEG]),
    .conv_en(converter_enable),
    .pos_src(route_pos),
    .neg_from_conv(route_neg_conv),
    .neg_pin(route_neg_pin)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Disable bits gathered into pin order
  logic [CONV_PINS-1:0] conv_off_vec; // Per-pin buffer disable
  always_comb begin
    conv_off_vec = '0;
    // Low register: pins 0..2 in bits 2:0, pins 3..6 in bits 7:4
    conv_off_vec[2:0] = st_ff.dis_low[2:0];
    conv_off_vec[6:3] = st_ff.dis_low[7:4];
    // High register: pins 7..10 in bits 7:4
    conv_off_vec[10:7] = st_ff.dis_high[7:ACP_DH_LSB];
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic flag_set; // Hardware event this cycle
    logic flag_clr; // Vector or write-one clear
    logic [7:0] a_view; // Control A as read back
    flag_set = 1'b0;
    flag_clr = 1'b0;
    a_view = 8'h00;
    nxt_st = st_ff;
    if (clk_en) begin
      flag_set = sync.event_hit;
      flag_clr = irq_vector_ack;

      // Register writes
      if (reg_wr) begin
        if (hit(reg_addr, ACP_OFF_CTRL_A)) begin
          // Flag and result are not stored from the write data
          nxt_st.ctrl_a = (reg_wdata & ACP_MASK_CTRL_A) |
                          (st_ff.ctrl_a & ~ACP_MASK_CTRL_A);
          if (reg_wdata[ACP_A_FLAG]) begin
            flag_clr = 1'b1;
          end
        end else if (hit(reg_addr, ACP_OFF_CTRL_B)) begin
          nxt_st.ctrl_b = reg_wdata & ACP_MASK_CTRL_B;
        end else if (hit(reg_addr, ACP_OFF_DISABLE_LOW)) begin
          nxt_st.dis_low = reg_wdata;
        end else if (hit(reg_addr, ACP_OFF_DISABLE_HIGH)) begin
          nxt_st.dis_high = reg_wdata & ACP_MASK_DISABLE_HIGH;
        end else begin
          // Unmapped write ignored
          nxt_st.dis_high = st_ff.dis_high;
        end
      end

      // Set wins over clear so no event is lost
      if (flag_set) begin
        nxt_st.ctrl_a[ACP_A_FLAG] = 1'b1;
      end else if (flag_clr) begin
        nxt_st.ctrl_a[ACP_A_FLAG] = 1'b0;
      end

      // Read data, valid the cycle after the strobe
      a_view = st_ff.ctrl_a;
      a_view[ACP_A_RESULT] = sync.result;
      if (reg_rd) begin
        if (hit(reg_addr, ACP_OFF_CTRL_A)) begin
          nxt_st.rdata = a_view;
        end else if (hit(reg_addr, ACP_OFF_CTRL_B)) begin
          nxt_st.rdata = st_ff.ctrl_b;
        end else if (hit(reg_addr, ACP_OFF_DISABLE_LOW)) begin
          nxt_st.rdata = st_ff.dis_low;
        end else if (hit(reg_addr, ACP_OFF_DISABLE_HIGH)) begin
          nxt_st.rdata = st_ff.dis_high;
        end else begin
          nxt_st.rdata = 8'h00; // Unmapped reads zero
        end
      end else begin
        nxt_st.rdata = 8'h00; // Data stand one cycle only
      end

      // Interrupt request from the new flag value
      nxt_st.irq = nxt_st.ctrl_a[ACP_A_FLAG] &
                   nxt_st.ctrl_a[ACP_A_IRQ_EN] &
                   global_irq_en;

      // Analog controls, registered so outputs come from flops
      nxt_st.power_off = nxt_st.ctrl_a[ACP_A_POWER_OFF];
      nxt_st.pos_src = route_pos;
      nxt_st.neg_conv = route_neg_conv;
      nxt_st.neg_pin = route_neg_pin;
      nxt_st.hyst_on = st_ff.ctrl_b[ACP_B_HYST_ON];
      nxt_st.hyst_lvl = st_ff.ctrl_b[ACP_B_HYST_LEVEL];

      // Buffer disable and gated pin reads
      nxt_st.conv_off = conv_off_vec;
      nxt_st.ref_off = st_ff.dis_low[ACP_DL_REF_PIN];
      nxt_st.conv_rd = conv_pin_raw & ~conv_off_vec;
      nxt_st.ref_rd = ref_pin_raw &
                      ~st_ff.dis_low[ACP_DL_REF_PIN];
    end
  end

  // Register the whole state, synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= ACP_RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops
  assign reg_rdata = st_ff.rdata;
  assign irq_req = st_ff.irq;
  assign cmp_power_off = st_ff.power_off;
  assign cmp_pos_source = st_ff.pos_src;
  assign cmp_neg_from_conv = st_ff.neg_conv;
  assign cmp_neg_pin = st_ff.neg_pin;
  assign hysteresis_on = st_ff.hyst_on;
  assign hysteresis_level = st_ff.hyst_lvl;
  assign conv_pin_buffer_off = st_ff.conv_off;
  assign ref_pin_buffer_off = st_ff.ref_off;
  assign conv_pin_read = st_ff.conv_rd;
  assign ref_pin_read = st_ff.ref_rd;

endmodule // acp_comparator_ctrl

// ===== acp_comparator_ctrl_bench.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module acp_comparator_ctrl_bench import acp_pkg::*;;
  logic mclk, rst_n, clk_en, reg_wr, reg_rd, global_irq_en;
  logic irq_vector_ack, irq_req, raw_result, converter_enable;
  logic cmp_power_off, cmp_neg_from_conv, hysteresis_on;
  logic hysteresis_level, ref_pin_raw, ref_pin_buffer_off, ref_pin_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, seed, lo, hi, cb, ca, d;
  logic [10:0] conv_pin_raw, conv_pin_buffer_off, conv_pin_read;
  logic [11:0] mv_a, mv_b, mv_c, mv_conv; // Analog pin levels, mV
  logic [1:0] cmp_pos_source, cmp_neg_pin;
  logic [3:0] r; // Expected positive and negative pins
  int n_mismatch, checks;
  logic [7:0] offs [5] = '{ACP_OFF_DISABLE_LOW, ACP_OFF_DISABLE_HIGH,
    ACP_OFF_CTRL_A, ACP_OFF_CTRL_B, 8'h30}; // Last one unmapped

  acp_comparator_ctrl dut (.mclk, .rst_n, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .global_irq_en,
    .irq_vector_ack, .irq_req, .raw_result, .converter_enable,
    .cmp_power_off, .cmp_pos_source, .cmp_neg_from_conv, .cmp_neg_pin,
    .hysteresis_on, .hysteresis_level, .conv_pin_raw, .ref_pin_raw,
    .conv_pin_buffer_off, .ref_pin_buffer_off, .conv_pin_read,
    .ref_pin_read);
  acp_analog_model core (.power_off(cmp_power_off),
    .pos_src(cmp_pos_source), .neg_conv(cmp_neg_from_conv),
    .neg_pin(cmp_neg_pin), .mv_a, .mv_b, .mv_c, .mv_conv,
    .result(raw_result));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  ////////////////////////////////////////
  // Shared checks, bus cycles and expectations
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Write strobe stays up until the next task lowers it, so no double drive
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    v = reg_rdata; // Data stand only in this cycle
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  function automatic logic [10:0] pin_dis(input logic [7:0] l,
                                          input logic [7:0] h);
    return {h[7:4], l[7:4], l[2:0]};
  endfunction
  function automatic logic [3:0] route(input logic [2:0] s);
    case (s)
      3'h0: return {ACP_PIN_A, ACP_PIN_B};
      3'h1: return {ACP_PIN_A, ACP_PIN_C};
      3'h2: return {ACP_PIN_B, ACP_PIN_A};
      3'h3: return {ACP_PIN_B, ACP_PIN_C};
      3'h4: return {ACP_PIN_C, ACP_PIN_A};
      default: return {ACP_PIN_C, ACP_PIN_B};
    endcase
  endfunction
  function automatic logic hit(input logic [1:0] m, input logic rise);
    case (m)
      ACP_MODE_TOGGLE: return 1'b1;
      ACP_MODE_FALL: return !rise;
      ACP_MODE_RISE: return rise;
      default: return 1'b0;
    endcase
  endfunction
  task automatic stop_test;
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Run is a few hundred cycles; ten times that means a hang
  initial begin
    #(3000 * 100);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test;
  end
  ////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, global_irq_en, irq_vector_ack} = '0;
    {converter_enable, ref_pin_raw, conv_pin_raw} = '0;
    {reg_addr, reg_wdata, mv_conv} = '0;
    clk_en = 1'b1;
    mv_a = 12'h064;
    mv_b = 12'h0C8;
    mv_c = 12'h190;
    seed = 8'h56;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    wr(8'h30, 8'hFF);
    foreach (offs[k]) begin
      rd(offs[k], d);
      chk(d, 8'h00);
    end
    // Random register contents against pins and routing
    for (int i = 0; i < 8; i++) begin
      lo = rnd();
      hi = rnd();
      cb = rnd();
      ca = rnd() & 8'hC4;
      converter_enable <= lo[3] ^ hi[0];
      conv_pin_raw <= {hi[2:0], cb};
      ref_pin_raw <= cb[5];
      wr(ACP_OFF_DISABLE_LOW, lo); // Analog pins shed buffers
      wr(ACP_OFF_DISABLE_HIGH, hi);
      wr(ACP_OFF_CTRL_B, cb);
      wr(ACP_OFF_CTRL_A, ca);
      rd(ACP_OFF_DISABLE_LOW, d);
      chk(d, lo);
      rd(ACP_OFF_DISABLE_HIGH, d);
      chk(d, hi & ACP_MASK_DISABLE_HIGH);
      rd(ACP_OFF_CTRL_B, d);
      chk(d, cb & ACP_MASK_CTRL_B);
      rd(ACP_OFF_CTRL_A, d);
      chk(d & 8'hC4, ca);
      r = route(cb[2:0]);
      chk(cmp_pos_source, ca[6] ? ACP_PIN_BANDGAP : r[3:2]);
      chk(cmp_neg_from_conv, ca[2] & ~converter_enable);
      if (!(ca[2] & ~converter_enable)) chk(cmp_neg_pin, r[1:0]);
      chk({hysteresis_on, hysteresis_level}, cb[7:6]);
      chk(cmp_power_off, ca[7]);
      chk(conv_pin_buffer_off, pin_dis(lo, hi));
      chk(conv_pin_read, {hi[2:0], cb} & ~pin_dis(lo, hi));
      chk({ref_pin_buffer_off, ref_pin_read}, {lo[3], cb[5] & ~lo[3]});
    end
    // Frozen clock enable must drop a write
    clk_en <= 1'b0;
    wr(ACP_OFF_DISABLE_LOW, ~lo);
    idle(1);
    clk_en <= 1'b1;
    rd(ACP_OFF_DISABLE_LOW, d);
    chk(d, lo);
    // Every event mode: rise, acknowledge, fall, write-one clear
    for (int m = 0; m < 4; m++) begin
      mv_a <= 12'h064;
      wr(ACP_OFF_CTRL_B, 8'h00);
      wr(ACP_OFF_CTRL_A, m[7:0]); // Enable off while mode moves
      idle(6);
      wr(ACP_OFF_CTRL_A, 8'h18 | m[7:0]);
      global_irq_en <= 1'b1;
      idle(3);
      chk(irq_req, 1'b0);
      mv_a <= 12'h12C;
      idle(6);
      chk(irq_req, hit(m[1:0], 1'b1));
      rd(ACP_OFF_CTRL_A, d);
      chk(d[5:4], {1'b1, hit(m[1:0], 1'b1)});
      global_irq_en <= 1'b0;
      idle(2);
      chk(irq_req, 1'b0);
      global_irq_en <= 1'b1;
      irq_vector_ack <= 1'b1;
      idle(1);
      irq_vector_ack <= 1'b0;
      idle(3);
      chk(irq_req, 1'b0);
      mv_a <= 12'h064;
      idle(6);
      chk(irq_req, hit(m[1:0], 1'b0));
      wr(ACP_OFF_CTRL_A, 8'h18 | m[7:0]);
      idle(3);
      chk(irq_req, 1'b0);
      wr(ACP_OFF_CTRL_A, m[7:0]);
    end
    idle(2);
    stop_test;
  end
endmodule // acp_comparator_ctrl_bench

// ===== acp_comparator_ctrl_checker.sv
// Port-level assertions for the comparator control block
`timescale 1ns/1ps
module acp_comparator_ctrl_checker import acp_pkg::*; #(
  parameter int CONV_PINS = 11
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic global_irq_en,
  input wire logic converter_enable,
  input wire logic irq_req,
  input wire logic cmp_power_off,
  input wire logic [1:0] cmp_pos_source,
  input wire logic cmp_neg_from_conv,
  input wire logic hysteresis_on,
  input wire logic hysteresis_level,
  input wire logic [CONV_PINS-1:0] conv_pin_buffer_off,
  input wire logic [CONV_PINS-1:0] conv_pin_read,
  input wire logic ref_pin_buffer_off,
  input wire logic ref_pin_read
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wr_a; // Accepted write to control A
  logic wr_b; // Accepted write to control B
  assign wr_a = reg_wr && clk_en && reg_addr == ACP_OFF_CTRL_A;
  assign wr_b = reg_wr && clk_en && reg_addr == ACP_OFF_CTRL_B;
  ////////////////////////////////////////
  property p_power;
    wr_a |=> cmp_power_off == $past(reg_wdata[ACP_A_POWER_OFF]);
  endproperty
  a_power: assert property (p_power)
    else $error("power-off bit not taken");
  // Hysteresis outputs trail control B by one flop
  property p_hyst;
    wr_b ##1 clk_en |=> {hysteresis_on, hysteresis_level} ==
      $past(reg_wdata[7:6], 2);
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("hysteresis bits not taken");
  // Routing output may sit one flop behind the register
  property p_bandgap;
    wr_a && reg_wdata[6] ##1 !wr_a && clk_en |-> ##[0:1]
      cmp_pos_source == ACP_PIN_BANDGAP;
  endproperty
  a_bandgap: assert property (p_bandgap)
    else $error("reference not routed to positive input");
  property p_mux;
    wr_a && reg_wdata[2] && !converter_enable ##1 !wr_a &&
      !converter_enable && clk_en ##1 !converter_enable |->
      cmp_neg_from_conv;
  endproperty
  a_mux: assert property (p_mux)
    else $error("converter mux not on negative input");
  property p_conv_off;
    $past(clk_en) && cmp_neg_from_conv |-> !$past(converter_enable);
  endproperty
  a_conv_off: assert property (p_conv_off)
    else $error("converter mux used while converter on");
  property p_global;
    clk_en && !global_irq_en |=> !irq_req;
  endproperty
  a_global: assert property (p_global)
    else $error("request without global enable");
  property p_pin;
    clk_en |=> (conv_pin_read & conv_pin_buffer_off &
      $past(conv_pin_buffer_off)) == '0;
  endproperty
  a_pin: assert property (p_pin)
    else $error("disabled converter pin reads one");
  property p_ref;
    clk_en |=> !(ref_pin_read && ref_pin_buffer_off &&
      $past(ref_pin_buffer_off));
  endproperty
  a_ref: assert property (p_ref)
    else $error("disabled reference pin reads one");
  c_irq: cover property ($rose(irq_req));
  c_bandgap: cover property (cmp_pos_source == ACP_PIN_BANDGAP);
  c_conv: cover property ($rose(cmp_neg_from_conv));
endmodule // acp_comparator_ctrl_checker

bind acp_comparator_ctrl acp_comparator_ctrl_checker #(
  .CONV_PINS(CONV_PINS)
) u_chk (.mclk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
  .global_irq_en, .converter_enable, .irq_req, .cmp_power_off,
  .cmp_pos_source, .cmp_neg_from_conv, .hysteresis_on,
  .hysteresis_level, .conv_pin_buffer_off, .conv_pin_read,
  .ref_pin_buffer_off, .ref_pin_read);

// ===== acp_input_route.sv
// Routing decode for comparator positive and negative inputs
`timescale 1ns/1ps
module acp_input_route import acp_pkg::*; (
  input wire logic [2:0] sel,
  input wire logic bandgap,
  input wire logic mux_neg,
  input wire logic conv_en,
  output logic [1:0] pos_src,
  output logic neg_from_conv,
  output logic [1:0] neg_pin
);

  // Combinational input routing
  always_comb begin
    // Positive from selected pin unless bandgap replaces it
    case (sel)
      3'h0, 3'h1: pos_src = ACP_PIN_A;
      3'h2, 3'h3: pos_src = ACP_PIN_B;
      default: pos_src = ACP_PIN_C;
    endcase
    if (bandgap) begin
      pos_src = ACP_PIN_BANDGAP;
    end
    // Negative pin from the dedicated pins; converter mux to negative only while the converter is off
    case (sel)
      3'h0: neg_pin = ACP_PIN_B;
      3'h1: neg_pin = ACP_PIN_C;
      3'h2: neg_pin = ACP_PIN_A;
      3'h3: neg_pin = ACP_PIN_C;
      3'h4: neg_pin = ACP_PIN_A;
      default: neg_pin = ACP_PIN_B;
    endcase
    neg_from_conv = mux_neg & ~conv_en;
  end

endmodule // acp_input_route

// ===== acp_pkg.sv
// Package: comparator control register map, fields, reset values
package acp_pkg;

  // Register offsets
  localparam logic [7:0] ACP_OFF_DISABLE_LOW = 8'h01;
  localparam logic [7:0] ACP_OFF_CTRL_A = 8'h08;
  localparam logic [7:0] ACP_OFF_CTRL_B = 8'h09;
  localparam logic [7:0] ACP_OFF_DISABLE_HIGH = 8'h02;

  // Control register A fields
  localparam int ACP_A_POWER_OFF = 7;
  localparam int ACP_A_BANDGAP = 6;
  localparam int ACP_A_RESULT = 5;
  localparam int ACP_A_FLAG = 4;
  localparam int ACP_A_IRQ_EN = 3;
  localparam int ACP_A_MUX_NEG = 2;
  localparam int ACP_A_MODE_HI = 1;
  localparam int ACP_A_MODE_LO = 0;

  // Control register B fields
  localparam int ACP_B_HYST_ON = 7;
  localparam int ACP_B_HYST_LEVEL = 6;
  localparam int ACP_B_SEL_HI = 2;

  // Disable register fields
  localparam int ACP_DL_REF_PIN = 3;
  localparam int ACP_DH_LSB = 4;

  // Reset values
  localparam logic [7:0] ACP_RST_CTRL_A = 8'h00;
  localparam logic [7:0] ACP_RST_CTRL_B = 8'h00;
  localparam logic [7:0] ACP_RST_DISABLE_LOW = 8'h00;
  localparam logic [7:0] ACP_RST_DISABLE_HIGH = 8'h00;

  // Writable bit masks
  localparam logic [7:0] ACP_MASK_CTRL_A = 8'hCF;
  localparam logic [7:0] ACP_MASK_CTRL_B = 8'hC7;
  localparam logic [7:0] ACP_MASK_DISABLE_HIGH = 8'hF0;

  // Interrupt modes
  localparam logic [1:0] ACP_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] ACP_MODE_RESERVED = 2'h1;
  localparam logic [1:0] ACP_MODE_FALL = 2'h2;
  localparam logic [1:0] ACP_MODE_RISE = 2'h3;

  // Input selection codes
  localparam logic [1:0] ACP_PIN_A = 2'h0;
  localparam logic [1:0] ACP_PIN_B = 2'h1;
  localparam logic [1:0] ACP_PIN_C = 2'h2;
  localparam logic [1:0] ACP_PIN_BANDGAP = 2'h3;

  // Event edge test, used by the detector only
  function automatic logic acp_event(input logic [1:0] mode,
                                     input logic prev,
                                     input logic cur);
    case (mode)
      ACP_MODE_TOGGLE: acp_event = prev ^ cur;
      ACP_MODE_FALL: acp_event = prev & ~cur;
      ACP_MODE_RISE: acp_event = ~prev & cur;
      default: acp_event = 1'b0;
    endcase
  endfunction

endpackage

// ===== acp_sync_detect.sv
// Two-stage synchronizer and event detector for the comparator output
`timescale 1ns/1ps
module acp_sync_detect import acp_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic raw_result,
  acp_sync_if.producer sync
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic meta; // First stage, read only by second
    logic stable; // Second stage
    logic prev; // Stable value one clock ago
  } acp_sd_state_type;

  acp_sd_state_type st_ff;
  acp_sd_state_type nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.meta = raw_result;
      nxt_st.stable = st_ff.meta;
      nxt_st.prev = st_ff.stable;
    end
  end

  // Register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync.result = st_ff.stable;
  assign sync.prev = st_ff.prev;
  // Compare clock to clock on the synchronized value only
  assign sync.event_hit = clk_en &
    acp_event(sync.mode, st_ff.prev, st_ff.stable);

endmodule // acp_sync_detect

// ===== acp_sync_if.sv
// Interface: synchronized comparator result and edge event between modules
`timescale 1ns/1ps
interface acp_sync_if;
  logic result; // Synchronized comparator result
  logic prev; // Result one clock earlier
  logic event_hit; // Selected event seen this cycle
  logic [1:0] mode; // Interrupt mode select
  modport producer (output result, output prev, output event_hit,
    input mode);
  modport consumer (input result, input prev, input event_hit,
    output mode);
endinterface
